//--- rtl/emi_pkg.sv
package emi_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Memory modes.
   localparam logic [1:0] EMI_MODE_INTERNAL  = 2'h0;
   localparam logic [1:0] EMI_MODE_SPLIT_NB  = 2'h1;
   localparam logic [1:0] EMI_MODE_SPLIT_BS  = 2'h2;
   localparam logic [1:0] EMI_MODE_EXTERNAL  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions of the timing register.
   localparam int EMI_TC_SETUP_LSB = 6;
   localparam int EMI_TC_WIDTH_LSB = 2;
   localparam int EMI_TC_HOLD_LSB  = 0;

   // Reset values: largest delays, widest latch strobe.
   localparam logic [7:0] EMI_TC_RESET    = 8'hFF;
   localparam logic [1:0] EMI_LATCH_RESET = 2'h3;

   // Default internal RAM size in bytes and its address width.
   localparam int EMI_RAM_BYTES = 4096;
   localparam int EMI_RAM_AW    = 12;

   // Fixed overhead of an off-chip access in clock cycles.
   localparam int EMI_FIXED_CYCLES = 4;

   typedef enum logic [6:0] {
      EMI_IDLE   = 7'b000_0001,
      EMI_LATCHH = 7'b000_0010,
      EMI_LATCHL = 7'b000_0100,
      EMI_SETUP  = 7'b000_1000,
      EMI_STROBE = 7'b001_0000,
      EMI_HOLD   = 7'b010_0000,
      EMI_DONE   = 7'b100_0000
   } emi_state_t;

endpackage

//--- rtl/emi_phase_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Down counter that reports when a loaded count of cycles has elapsed.
module emi_phase_counter #(
   parameter int W = 4
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              zero_o
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   always_comb begin
      next_cnt = cnt;
      if (load_i) begin
         next_cnt = count_i;
      end else if (cnt != '0) begin
         next_cnt = cnt - W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign zero_o = (cnt == '0);

endmodule

`default_nettype wire

//--- rtl/emi_core.sv
`timescale 1ns/1ps
`default_nettype none

module emi_core
   import emi_pkg::*;
#(
   parameter int RAM_AW = EMI_RAM_AW
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Configuration.
   input  wire logic        bus_mux_select_i,
   input  wire logic [1:0]  mem_mode_i,
   input  wire logic [1:0]  latch_width_field_i,
   input  wire logic [7:0]  strobe_timing_wdata_i,
   input  wire logic        strobe_timing_we_i,
   output logic [7:0]       strobe_timing_reg_o,
   input  wire logic [7:0]  bank_page_reg_i,
   // CPU side.
   input  wire logic        req_i,
   input  wire logic        write_i,
   input  wire logic        wide_i,
   input  wire logic [15:0] data_pointer_i,
   input  wire logic [7:0]  index_reg_i,
   input  wire logic [7:0]  wdata_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             offchip_o,
   output logic [7:0]       rdata_o,
   // External pins.
   output logic [7:0]       addr_hi_o,
   output logic             addr_hi_oe_n_o,
   output logic [7:0]       addr_lo_o,
   output logic             addr_lo_oe_n_o,
   output logic [7:0]       data_o,
   output logic             data_oe_n_o,
   input  wire logic [7:0]  data_i,
   output logic             latch_strobe_o,
   output logic             rd_n_o,
   output logic             wr_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // On-chip RAM and timing register.

   logic [7:0]        ram [0:(1<<RAM_AW)-1];
   logic [7:0]        tc;
   logic [7:0]        next_tc;
   logic [7:0]        din_s1;
   logic [7:0]        din_s2;

   always_comb begin
      next_tc = tc;
      if (strobe_timing_we_i) begin
         next_tc = strobe_timing_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tc <= EMI_TC_RESET;
      end else begin
         tc <= next_tc;
      end
   end

   always_ff @(posedge clk_i) begin
      din_s1 <= data_i;
      din_s2 <= din_s1;
   end

   assign strobe_timing_reg_o = tc;

   logic [1:0] setup_f;
   logic [3:0] width_f;
   logic [1:0] hold_f;
   assign setup_f = tc[EMI_TC_SETUP_LSB +: 2];
   assign width_f = tc[EMI_TC_WIDTH_LSB +: 4];
   assign hold_f  = tc[EMI_TC_HOLD_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////////
   // Effective address and routing.

   logic [15:0] eff_addr;
   logic        above;
   logic        go_off;
   logic        drive_hi;

   always_comb begin
      eff_addr = wide_i ? data_pointer_i : {bank_page_reg_i, index_reg_i};
      above    = (eff_addr >> RAM_AW) != 16'h0000;
      go_off   = 1'b0;
      drive_hi = 1'b1;
      unique case (mem_mode_i)
         EMI_MODE_INTERNAL: begin
            go_off = 1'b0;
         end
         EMI_MODE_SPLIT_NB: begin
            go_off   = above;
            drive_hi = wide_i;
         end
         EMI_MODE_SPLIT_BS: begin
            go_off = above;
         end
         EMI_MODE_EXTERNAL: begin
            go_off   = 1'b1;
            drive_hi = wide_i;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access sequencer.

   emi_state_t  state;
   emi_state_t  next_state;
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic [7:0]  wd;
   logic [7:0]  next_wd;
   logic        wr;
   logic        next_wr;
   logic        hi_en;
   logic        next_hi_en;
   logic        off;
   logic        next_off;
   logic [7:0]  rd;
   logic [7:0]  next_rd;
   logic        dn;
   logic        next_dn;
   logic        cap1;
   logic        next_cap1;
   logic        cap2;
   logic        next_cap2;
   logic        ld;
   logic [3:0]  ld_val;
   logic        cnt_zero;

   emi_phase_counter #(.W(4)) u_cnt (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (ld),
      .count_i   (ld_val),
      .zero_o    (cnt_zero)
   );

   always_comb begin
      next_state = state;
      next_addr  = addr;
      next_wd    = wd;
      next_wr    = wr;
      next_hi_en = hi_en;
      next_off   = off;
      next_rd    = rd;
      next_dn    = 1'b0;
      ld         = 1'b0;
      ld_val     = 4'h0;
      // Read data is taken two edges after the strobe ends, once the sample
      // from its last cycle has crossed the pin synchroniser.
      next_cap1  = (state == EMI_STROBE) && cnt_zero && !wr;
      next_cap2  = cap1;
      if (cap2) begin
         next_rd = din_s2;
      end
      unique case (state)
         EMI_IDLE: begin
            if (req_i && go_off) begin
               next_addr  = eff_addr;
               next_wd    = wdata_i;
               next_wr    = write_i;
               next_hi_en = drive_hi;
               next_off   = 1'b1;
               ld         = 1'b1;
               if (!bus_mux_select_i) begin
                  ld_val     = {2'b00, latch_width_field_i};
                  next_state = EMI_LATCHH;
               end else begin
                  ld_val     = {2'b00, setup_f};
                  next_state = EMI_SETUP;
               end
            end else if (req_i) begin
               // On-chip access: wrapped index, pins untouched.
               next_off = 1'b0;
               next_dn  = 1'b1;
               next_rd  = ram[eff_addr[RAM_AW-1:0]];
            end
         end
         EMI_LATCHH: begin
            if (cnt_zero) begin
               ld         = 1'b1;
               ld_val     = {2'b00, latch_width_field_i};
               next_state = EMI_LATCHL;
            end
         end
         EMI_LATCHL: begin
            if (cnt_zero) begin
               ld         = 1'b1;
               ld_val     = {2'b00, setup_f};
               next_state = EMI_SETUP;
            end
         end
         EMI_SETUP: begin
            if (cnt_zero) begin
               ld         = 1'b1;
               ld_val     = width_f;
               next_state = EMI_STROBE;
            end
         end
         EMI_STROBE: begin
            if (cnt_zero) begin
               ld         = 1'b1;
               ld_val     = {2'b00, hold_f};
               next_state = EMI_HOLD;
            end
         end
         EMI_HOLD: begin
            if (cnt_zero) begin
               next_state = EMI_DONE;
            end
         end
         EMI_DONE: begin
            next_dn    = 1'b1;
            next_state = EMI_IDLE;
         end
         default: begin
            next_state = EMI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= EMI_IDLE;
         addr  <= 16'h0000;
         wd    <= 8'h00;
         wr    <= 1'b0;
         hi_en <= 1'b0;
         off   <= 1'b0;
         rd    <= 8'h00;
         dn    <= 1'b0;
         cap1  <= 1'b0;
         cap2  <= 1'b0;
      end else begin
         state <= next_state;
         addr  <= next_addr;
         wd    <= next_wd;
         wr    <= next_wr;
         hi_en <= next_hi_en;
         off   <= next_off;
         rd    <= next_rd;
         dn    <= next_dn;
         cap1  <= next_cap1;
         cap2  <= next_cap2;
      end
   end

   // Internal RAM write, taken only for on-chip routing.
   always_ff @(posedge clk_i) begin
      if (state == EMI_IDLE && req_i && write_i && !go_off) begin
         ram[eff_addr[RAM_AW-1:0]] <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive.

   logic active;
   logic in_latch;
   logic strobe;
   assign active   = (state != EMI_IDLE) && (state != EMI_DONE);
   assign in_latch = (state == EMI_LATCHH);
   assign strobe   = (state == EMI_STROBE);

   assign busy_o         = (state != EMI_IDLE);
   assign done_o         = dn;
   assign offchip_o      = off;
   assign rdata_o        = rd;
   assign addr_hi_o      = addr[15:8];
   assign addr_hi_oe_n_o = !(active && hi_en);
   // Separate low-address pins are used only in non-multiplexed form.
   assign addr_lo_o      = addr[7:0];
   assign addr_lo_oe_n_o = !(active && bus_mux_select_i);
   // Shared pins carry the low address in the latch-high phase, then data.
   assign data_o         = (!bus_mux_select_i && in_latch) ? addr[7:0] : wd;
   assign data_oe_n_o    = !(active && ((!bus_mux_select_i && in_latch) || wr));
   assign latch_strobe_o = in_latch;
   assign rd_n_o         = !(strobe && !wr);
   assign wr_n_o         = !(strobe && wr);

endmodule

`default_nettype wire

//--- bench/emi_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module emi_core_properties
   import emi_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       bus_mux_select_i,
   input  wire logic [1:0] mem_mode_i,
   input  wire logic [1:0] latch_width_field_i,
   input  wire logic [7:0] strobe_timing_reg_o,
   input  wire logic       addr_hi_oe_n_o,
   input  wire logic       addr_lo_oe_n_o,
   input  wire logic       data_oe_n_o,
   input  wire logic       latch_strobe_o,
   input  wire logic       rd_n_o,
   input  wire logic       wr_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [4:0] low_cnt;
   logic [2:0] ale_cnt;
   // Count how long the strobe and the latch strobe have been active.
   always_ff @(posedge clk_i) begin
      low_cnt <= (rd_n_o && wr_n_o) ? 5'h0 : low_cnt + 5'h1;
      ale_cnt <= latch_strobe_o ? ale_cnt + 3'h1 : 3'h0;
   end
   sequence s_strobe_end;
      $rose(rd_n_o && wr_n_o);
   endsequence
   sequence s_latch_end;
      $fell(latch_strobe_o);
   endsequence
   strobe_width_a: assert property (s_strobe_end |->
      low_cnt == {1'b0, strobe_timing_reg_o[5:2]} + 5'h1) else $error("strobe width wrong");
   latch_width_a: assert property (s_latch_end |->
      ale_cnt == {1'b0, latch_width_field_i} + 3'h1) else $error("latch width wrong");
   nonmux_latch_a: assert property (bus_mux_select_i |-> !latch_strobe_o)
      else $error("latch strobe in non-multiplexed form");
   internal_quiet_a: assert property (mem_mode_i == 2'h0 |-> rd_n_o && wr_n_o
      && !latch_strobe_o && addr_hi_oe_n_o && addr_lo_oe_n_o) else $error("bus active");
   timing_reset_a: assert property ($fell(sys_rst_i) |->
      strobe_timing_reg_o == EMI_TC_RESET) else $error("timing reset value wrong");
   latch_phase_a: assert property (latch_strobe_o |-> !data_oe_n_o && rd_n_o && wr_n_o)
      else $error("latch phase without address");
   write_drive_a: assert property (!wr_n_o |-> !data_oe_n_o)
      else $error("write data not driven");
   read_release_a: assert property (!rd_n_o |-> data_oe_n_o)
      else $error("data driven during read");
   mux_lo_off_a: assert property (!bus_mux_select_i |-> addr_lo_oe_n_o)
      else $error("low address pins driven in multiplexed form");
   nonmux_addr_a: assert property (bus_mux_select_i && !(rd_n_o && wr_n_o)
      |-> !addr_lo_oe_n_o) else $error("low address not driven");
endmodule
`default_nettype wire

//--- bench/emi_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module emi_ext_mem (
   input  wire logic        clk_i,
   input  wire logic        mux_i,
   input  wire logic [7:0]  port_hi_i,
   input  wire logic [7:0]  ahi_i,
   input  wire logic        ahi_oe_n_i,
   input  wire logic [7:0]  alo_i,
   input  wire logic [7:0]  bus_i,
   input  wire logic        latch_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   output logic [7:0]       bus_o,
   output logic [15:0]      addr_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] lo_q;
   logic [7:0] last;
   logic [15:0] addr;
   // Undriven upper lines take the port latch value.
   assign addr = {ahi_oe_n_i ? port_hi_i : ahi_i, mux_i ? alo_i : lo_q};
   // A released bus shows the inverse of its last value.
   assign bus_o = !rd_n_i ? mem[addr] : ~last;
   always @(posedge clk_i) begin
      if (!rd_n_i) last <= bus_o;
      if (latch_i) lo_q <= bus_i;
      if (!wr_n_i) mem[addr] <= bus_i;
      if (!(rd_n_i && wr_n_i)) addr_o <= addr;
   end
endmodule
`default_nettype wire

//--- bench/emi_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module emi_core_tb_top;
   import emi_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, mux = 0, req = 0, wr = 0, wide = 0, we = 0;
   logic [1:0] mode = 0, lw = 0;
   logic [7:0] twd = 0, bank = 0, idx = 0, wd = 0, phi = 0;
   logic [15:0] dp = 0, ma;
   logic busy, done, off, ahoe, aloe, doe, ale, rdn, wrn;
   logic [7:0] rdata, tc, ahi, alo, dout, mbus, bus;
   logic [31:0] seed = 32'h0000_0035;
   logic [16:0] e;
   int fails = 0, compares = 0, cyc, k;
   assign bus = doe ? mbus : dout;
   emi_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_mux_select_i(mux),
      .mem_mode_i(mode), .latch_width_field_i(lw), .strobe_timing_wdata_i(twd),
      .strobe_timing_we_i(we), .strobe_timing_reg_o(tc), .bank_page_reg_i(bank),
      .req_i(req), .write_i(wr), .wide_i(wide), .data_pointer_i(dp), .index_reg_i(idx),
      .wdata_i(wd), .busy_o(busy), .done_o(done), .offchip_o(off), .rdata_o(rdata),
      .addr_hi_o(ahi), .addr_hi_oe_n_o(ahoe), .addr_lo_o(alo), .addr_lo_oe_n_o(aloe),
      .data_o(dout), .data_oe_n_o(doe), .data_i(bus), .latch_strobe_o(ale),
      .rd_n_o(rdn), .wr_n_o(wrn));
   emi_ext_mem u_mem (.clk_i(clk_i), .mux_i(mux), .port_hi_i(phi), .ahi_i(ahi),
      .ahi_oe_n_i(ahoe), .alo_i(alo), .bus_i(bus), .latch_i(ale), .rd_n_i(rdn),
      .wr_n_i(wrn), .bus_o(mbus), .addr_o(ma));
   initial forever #5 clk_i = ~clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Bit 16 is the off-chip flag, the rest is the address seen on the bus.
   function automatic logic [16:0] expect_addr();
      logic [15:0] eff;
      eff = wide ? dp : {bank, idx};
      return {mode == 2'h3 || (mode != 2'h0 && eff >= 16'h1000),
              (wide || mode == 2'h2) ? eff : {phi, idx}};
   endfunction
   task automatic finish_test();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic w);
      @(negedge clk_i);
      req = 1;
      wr = w;
      @(negedge clk_i);
      req = 0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 300) begin
         @(negedge clk_i);
         cyc++;
      end
      if (cyc >= 300) begin
         fails++;
         finish_test();
      end
      check(busy, 1'b0);
   endtask
   initial begin
      repeat (3) @(negedge clk_i);
      sys_rst_i = 0;
      check(tc, EMI_TC_RESET);
      for (int i = 0; i < 80; i++) begin
         {mode, mux, lw, twd} = rnd();
         {wide, dp, bank, idx} = rnd();
         {wd, phi} = rnd();
         if (rnd() & 1) begin
            dp &= 16'h0FFF;
            bank &= 8'h0F;
         end
         if (i < 3) begin
            wide = 1;
            mode = (i < 2) ? 2'h1 : 2'h3;
            dp = 16'h0FFF + i[15:0];
         end
         we = 1;
         @(negedge clk_i);
         we = 0;
         check(tc, twd);
         e = expect_addr();
         access(1'b1);
         check(off, e[16]);
         if (e[16]) begin
            check(ma, e[15:0]);
            check(u_mem.mem[e[15:0]], wd);
            k = EMI_FIXED_CYCLES + 1 + twd[7:6] + twd[5:2] + twd[1:0] + (mux ? 0 : 2 * lw + 2);
            check(17'(cyc), 17'(k));
         end
         if (mode == 2'h0) begin
            dp ^= 16'hF000;
            bank ^= 8'hF0;
         end
         access(1'b0);
         check(rdata, wd);
      end
      finish_test();
   end
endmodule
bind emi_core emi_core_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .bus_mux_select_i(bus_mux_select_i), .mem_mode_i(mem_mode_i),
   .latch_width_field_i(latch_width_field_i), .strobe_timing_reg_o(strobe_timing_reg_o),
   .addr_hi_oe_n_o(addr_hi_oe_n_o), .addr_lo_oe_n_o(addr_lo_oe_n_o),
   .data_oe_n_o(data_oe_n_o), .latch_strobe_o(latch_strobe_o), .rd_n_o(rd_n_o),
   .wr_n_o(wr_n_o));
`default_nettype wire
